// ---- include/eeprom_autoload_defines.svh ----
// Constants for the configuration autoload and mode strap block
`ifndef EEPROM_AUTOLOAD_DEFINES_SVH
`define EEPROM_AUTOLOAD_DEFINES_SVH

// System clock period
`define CLK_PERIOD_NS 10
// Serial clock half period, least time, and its cycle count
`define EE_SK_HALF_NS 500
`define EE_SK_HALF_CYC ((`EE_SK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Cycles after reset release before the straps are captured
`define STRAP_SETTLE_CYC 3'h4
// Last word address loaded, original and later variant
`define EE_LAST_V1 5'h1A
`define EE_LAST_V2 5'h1B
// Word holding the second configuration register and its activation bit
`define ISA_CFG2_IDX 5'h09
`define ACT_BIT 9
// Read command: start bit and read opcode
`define EE_CMD_READ 3'h6
// Frame layout: command bits, first data bit, last bit
`define EE_CMD_BITS 5'h09
`define EE_DATA_FIRST 5'h0A
`define EE_LAST_BIT 5'h19
// Byte sum of all loaded words that marks a good image
`define EE_CKSUM_OK 8'hFF
// Register default shown when nothing valid was loaded
`define CFG_DEFAULT 16'h0000

`endif

// ---- include/eeprom_autoload_pkg.sv ----
// Types for the configuration autoload and mode strap block
package eeprom_autoload_pkg;

	typedef enum logic [2:0] {
		LD_STRAP,
		LD_FRAME,
		LD_GAP,
		LD_CHECK,
		LD_DONE
	} load_st_t;

endpackage : eeprom_autoload_pkg

// ---- rtl/cfg_shadow_mem.sv ----
// Shadow storage for configuration words loaded from the serial EEPROM
`timescale 1ns/1ps

module cfg_shadow_mem (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Write port
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [15:0] wr_data,
	// Read port
	input wire logic [4:0] rd_addr,
	output logic [15:0] rd_data_q
);

	logic [15:0] mem [0:31];

	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rd_data_q <= 16'h0000;
		else
			rd_data_q <= mem[rd_addr];
	end

endmodule : cfg_shadow_mem

// ---- rtl/eeprom_autoload_mode_strap.sv ----
// Power-up mode strap capture and serial EEPROM configuration autoload
`timescale 1ns/1ps
`include "eeprom_autoload_defines.svh"

module eeprom_autoload_mode_strap #(
	parameter bit LATER_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Dual-purpose mode pin
	input wire logic shared_mem_select_n_in,
	output logic shared_mem_select_n_out,
	output logic shared_mem_select_n_oe,
	// Bus ownership from the master engine
	input wire logic bus_owner,
	// EEPROM presence strap
	input wire logic eeprom_present_strap,
	// Serial EEPROM
	output logic ee_cs,
	output logic ee_sk,
	output logic ee_di,
	input wire logic ee_do,
	// Configuration read port
	input wire logic [4:0] cfg_rd_addr,
	output logic [15:0] cfg_rd_data,
	// Status
	output logic master_mode,
	output logic load_busy,
	output logic load_done,
	output logic load_ok,
	output logic checksum_err,
	output logic device_active
);
	localparam logic [6:0] HALF_LAST = 7'(`EE_SK_HALF_CYC - 1);
	eeprom_autoload_pkg::load_st_t st_q, st_d;
	logic [2:0] pin_raw;
	logic [2:0] filt_q;
	logic [2:0] settle_q;
	logic strap_done_q, strap_master_q, strap_present_q;
	logic [6:0] half_q;
	logic sk_q, cs_q, di_q;
	logic [4:0] bit_q;
	logic [4:0] addr_q;
	logic [15:0] shift_q;
	logic [7:0] sum_q;
	logic act_q, done_q, ok_q, own_q;
	logic [15:0] mem_rd;
	logic [15:0] rd_q;
	wire tick = (half_q == HALF_LAST);
	wire [4:0] last_addr = LATER_VARIANT ? `EE_LAST_V2 : `EE_LAST_V1;
	wire [8:0] cmd_bits = {`EE_CMD_READ, 1'b0, addr_q};
	wire [8:0] cmd_sh = cmd_bits << bit_q;
	wire next_di = (bit_q < `EE_CMD_BITS) ? cmd_sh[8] : 1'b0;
	wire fall = (st_q == eeprom_autoload_pkg::LD_FRAME) && tick && sk_q;
	wire wr_en = (st_q == eeprom_autoload_pkg::LD_GAP) && tick;
	wire [7:0] sum_d = sum_q + shift_q[15:8] + shift_q[7:0];
	wire mode_filt = filt_q[0];
	wire present_filt = filt_q[1];
	wire do_filt = filt_q[2];
	assign pin_raw = {ee_do, eeprom_present_strap, shared_mem_select_n_in};
	// Three-stage synchronisers, value taken once stages two and three agree
	for (genvar gi = 0; gi < 3; gi++)
	begin : g_sync
		logic s1_q, s2_q, s3_q, f_q;
		assign filt_q[gi] = f_q;
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
			begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				f_q <= 1'b0;
			end
			else
			begin
				s1_q <= pin_raw[gi];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q)
					f_q <= s3_q;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			settle_q <= 3'h0;
			strap_done_q <= 1'b0;
			strap_master_q <= 1'b0;
			strap_present_q <= 1'b0;
		end
		else if (!strap_done_q)
		begin
			settle_q <= settle_q + 3'h1;
			if (settle_q == `STRAP_SETTLE_CYC)
			begin
				strap_done_q <= 1'b1;
				strap_master_q <= mode_filt;
				strap_present_q <= present_filt;
			end
		end
	end

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			eeprom_autoload_pkg::LD_STRAP:
				if (strap_done_q)
					st_d = strap_present_q ? eeprom_autoload_pkg::LD_FRAME
						: eeprom_autoload_pkg::LD_DONE;
			eeprom_autoload_pkg::LD_FRAME:
				if (fall && bit_q == `EE_LAST_BIT)
					st_d = eeprom_autoload_pkg::LD_GAP;
			eeprom_autoload_pkg::LD_GAP:
				if (tick)
					st_d = (addr_q == last_addr) ? eeprom_autoload_pkg::LD_CHECK
						: eeprom_autoload_pkg::LD_FRAME;
			eeprom_autoload_pkg::LD_CHECK:
				st_d = eeprom_autoload_pkg::LD_DONE;
			eeprom_autoload_pkg::LD_DONE:
				st_d = eeprom_autoload_pkg::LD_DONE;
			default:
				st_d = eeprom_autoload_pkg::LD_STRAP;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= eeprom_autoload_pkg::LD_STRAP;
		else
			st_q <= st_d;
	end

	// Serial clock and frame bit counter
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			half_q <= 7'h00;
			sk_q <= 1'b0;
			bit_q <= 5'h00;
			shift_q <= 16'h0000;
		end
		else
		begin
			half_q <= tick ? 7'h00 : half_q + 7'h01;
			if (st_q == eeprom_autoload_pkg::LD_FRAME && tick)
				sk_q <= !sk_q;
			if (fall && bit_q >= `EE_DATA_FIRST)
				shift_q <= {shift_q[14:0], do_filt};
			if (fall)
				bit_q <= (bit_q == `EE_LAST_BIT) ? 5'h00 : bit_q + 5'h01;
		end
	end

	// Pin drivers and word accumulation
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cs_q <= 1'b0;
			di_q <= 1'b0;
			addr_q <= 5'h00;
			sum_q <= 8'h00;
			act_q <= 1'b0;
			done_q <= 1'b0;
			ok_q <= 1'b0;
		end
		else
		begin
			cs_q <= (st_q == eeprom_autoload_pkg::LD_FRAME);
			di_q <= (st_q == eeprom_autoload_pkg::LD_FRAME) && next_di;
			if (wr_en)
			begin
				sum_q <= sum_d;
				addr_q <= addr_q + 5'h01;
				if (addr_q == `ISA_CFG2_IDX)
					act_q <= shift_q[`ACT_BIT];
			end
			if (st_q == eeprom_autoload_pkg::LD_CHECK)
				ok_q <= (sum_q == `EE_CKSUM_OK);
			if (st_d == eeprom_autoload_pkg::LD_DONE)
				done_q <= 1'b1;
		end
	end

	cfg_shadow_mem u_mem (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.wr_en(wr_en),
		.wr_addr(addr_q),
		.wr_data(shift_q),
		.rd_addr(cfg_rd_addr),
		.rd_data_q(mem_rd)
	);

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_q <= `CFG_DEFAULT;
			own_q <= 1'b0;
		end
		else
		begin
			rd_q <= ok_q ? mem_rd : `CFG_DEFAULT;
			own_q <= bus_owner && strap_master_q;
		end
	end

	assign cfg_rd_data = rd_q;
	assign ee_cs = cs_q;
	assign ee_sk = sk_q;
	assign ee_di = di_q;
	assign master_mode = strap_master_q;
	assign shared_mem_select_n_oe = strap_done_q && strap_master_q;
	assign shared_mem_select_n_out = !own_q;
	assign load_busy = strap_done_q && !done_q;
	assign load_done = done_q;
	assign load_ok = ok_q;
	assign checksum_err = done_q && strap_present_q && !ok_q;
	assign device_active = ok_q && act_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	property p_oe_master;
		shared_mem_select_n_oe |-> master_mode;
	endproperty
	a_oe_master: assert property (p_oe_master)
		else $error("Mode pin driven outside master mode");
	property p_owner_low;
		master_mode && bus_owner ##1 master_mode |-> !shared_mem_select_n_out;
	endproperty
	a_owner_low: assert property (p_owner_low)
		else $error("Bus owner not shown low on mode pin");
	property p_shared_input;
		strap_done_q && !master_mode |-> !shared_mem_select_n_oe;
	endproperty
	a_shared_input: assert property (p_shared_input)
		else $error("Shared memory mode pin is driven");
	property p_strap_take;
		$rose(strap_done_q) |-> master_mode == $past(mode_filt);
	endproperty
	a_strap_take: assert property (p_strap_take)
		else $error("Mode not taken from pin");
	property p_strap_hold;
		strap_done_q |=> $stable(master_mode) && $stable(strap_present_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("Strap value changed after capture");
	property p_load_start;
		$rose(strap_done_q) && strap_present_q |-> ##2 ee_cs;
	endproperty
	a_load_start: assert property (p_load_start)
		else $error("Autoload did not start after reset");
	property p_addr_range;
		wr_en |-> addr_q <= last_addr;
	endproperty
	a_addr_range: assert property (p_addr_range)
		else $error("Load beyond last word");
	property p_ckerr_default;
		load_done && !load_ok ##2 1'b1 |-> cfg_rd_data == `CFG_DEFAULT;
	endproperty
	a_ckerr_default: assert property (p_ckerr_default)
		else $error("Loaded data shown after failed load");
	property p_active;
		device_active |-> load_ok && act_q && load_done;
	endproperty
	a_active: assert property (p_active)
		else $error("Device active without good load and bit");

	c_good_load: cover property (load_done && load_ok && device_active);
	c_ckerr: cover property (checksum_err);
	c_owner: cover property (shared_mem_select_n_oe && !shared_mem_select_n_out);

endmodule : eeprom_autoload_mode_strap

// ---- bench/ee_serial_model.sv ----
// Behavioural serial EEPROM answering word reads
`timescale 1ns/1ps

module ee_serial_model (
	// Clock for the idle line pattern
	input wire logic clk_sys,
	// Serial link
	input wire logic ee_cs,
	input wire logic ee_sk,
	input wire logic ee_di,
	output logic ee_do
);
	logic [15:0] mem [32];
	logic [8:0] cmd_q;
	logic drive;
	logic drv_val;
	int bit_cnt;
	int frames;
	int cmd_err;

	initial
	begin
		ee_do = 1'b0;
		drive = 1'b0;
		bit_cnt = 0;
		frames = 0;
		cmd_err = 0;
	end

	always @(posedge ee_cs)
		frames++;

	always @(posedge ee_sk or negedge ee_cs)
	begin
		if (!ee_cs)
		begin
			bit_cnt = 0;
			drive = 1'b0;
		end
		else
		begin
			if (bit_cnt < 9)
				cmd_q = {cmd_q[7:0], ee_di};
			if (bit_cnt == 8 && cmd_q != {4'b1100, 5'(frames - 1)})
				cmd_err++;
			drive = bit_cnt >= 9 && bit_cnt <= 25;
			drv_val = (drive && bit_cnt >= 10) ?
				mem[cmd_q[4:0]][25 - bit_cnt] : 1'b0;
			bit_cnt++;
		end
	end

	// Released line toggles so a stale bit is never read
	always @(posedge clk_sys)
		ee_do <= drive ? drv_val : !ee_do;

endmodule : ee_serial_model

// ---- bench/tb.sv ----
// Self-checking bench for mode strap capture and EEPROM autoload
`timescale 1ns/1ps
`include "eeprom_autoload_defines.svh"

module tb;
	logic clk_sys;
	logic rst_b;
	logic [1:0] pin;
	logic bus_owner;
	logic present;
	logic [4:0] rd_addr;
	logic [1:0] oe, pout, mm, busy, done, ok, err, act;
	logic [15:0] img [32];
	int bad_count;
	int comparisons;

	for (genvar g = 0; g < 2; g++)
	begin : g_dut
		logic cs, sk, di, dout;
		logic [15:0] rd;
		eeprom_autoload_mode_strap #(
			.LATER_VARIANT(g == 0)
		) u_eeprom_autoload_mode_strap (
			.clk_sys(clk_sys), .rst_b(rst_b), .shared_mem_select_n_in(pin[g]),
			.shared_mem_select_n_out(pout[g]), .shared_mem_select_n_oe(oe[g]),
			.bus_owner(bus_owner), .eeprom_present_strap(present),
			.ee_cs(cs), .ee_sk(sk), .ee_di(di), .ee_do(dout),
			.cfg_rd_addr(rd_addr), .cfg_rd_data(rd), .master_mode(mm[g]),
			.load_busy(busy[g]), .load_done(done[g]), .load_ok(ok[g]),
			.checksum_err(err[g]), .device_active(act[g])
		);
		ee_serial_model u_ee_serial_model (
			.clk_sys(clk_sys), .ee_cs(cs), .ee_sk(sk), .ee_di(di), .ee_do(dout)
		);
	end

	initial
	begin
		clk_sys = 1'b0;
		forever #(`CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	end

	function automatic logic [7:0] byte_sum(input int last);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i <= last; i++)
			s = s + img[i][15:8] + img[i][7:0];
		return s;
	endfunction : byte_sum

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset(input logic [1:0] pins, input logic pres);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		pin <= pins;
		present <= pres;
		g_dut[0].u_ee_serial_model.frames = 0;
		g_dut[1].u_ee_serial_model.frames = 0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
	endtask : do_reset

	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		// Longest load is 28 words of about 2650 cycles each
		repeat (90000) @(posedge clk_sys);
		bad_count++;
		print_verdict;
	end

	initial
	begin
		rst_b = 1'b0;
		pin = 2'b00;
		bus_owner = 1'b0;
		present = 1'b0;
		rd_addr = 5'h00;
		bad_count = 0;
		comparisons = 0;
		void'($urandom(6271));
		for (int i = 0; i < 32; i++)
			img[i] = 16'($urandom);
		img[`ISA_CFG2_IDX][`ACT_BIT] = 1'b1;
		img[`EE_LAST_V2] = 16'h8000;
		if (byte_sum(`EE_LAST_V1) == 8'hFF)
			img[0] ^= 16'h0001;
		img[`EE_LAST_V2][7:0] = 8'hFF - byte_sum(`EE_LAST_V2);
		g_dut[0].u_ee_serial_model.mem = img;
		g_dut[1].u_ee_serial_model.mem = img;
		do_reset(2'b01, 1'b1);
		chk(mm, 2'b01);
		chk(oe, 2'b01);
		chk(busy, 2'b11);
		pin <= 2'b10;
		repeat (10) @(posedge clk_sys);
		#1 chk(mm, 2'b01);
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk_sys);
			bus_owner <= 1'($urandom_range(1));
			@(posedge clk_sys);
			#1 chk(pout[0], !bus_owner);
		end
		chk(oe, 2'b01);
		for (int n = 0; n < 80000 && done[0] !== 1'b1; n++)
			@(posedge clk_sys);
		#1 chk(done, 2'b11);
		chk({ok, err, act, busy}, 8'b0110_0100);
		chk(16'(g_dut[0].u_ee_serial_model.frames), 16'h001C);
		chk(16'(g_dut[1].u_ee_serial_model.frames), 16'h001B);
		chk(16'(g_dut[0].u_ee_serial_model.cmd_err), 16'h0000);
		chk(16'(g_dut[1].u_ee_serial_model.cmd_err), 16'h0000);
		for (int i = 0; i <= `EE_LAST_V2; i++)
		begin
			@(posedge clk_sys);
			rd_addr <= 5'(i);
			repeat (3) @(posedge clk_sys);
			#1 chk(g_dut[0].rd, img[i]);
			chk(g_dut[1].rd, `CFG_DEFAULT);
		end
		do_reset(2'b10, 1'b0);
		for (int n = 0; n < 1000 && done !== 2'b11; n++)
			@(posedge clk_sys);
		#1 chk({done, ok, err, act}, 8'b1100_0000);
		chk({mm, oe}, 4'b1010);
		chk(16'(g_dut[0].u_ee_serial_model.frames), 16'h0000);
		chk(g_dut[0].rd, `CFG_DEFAULT);
		@(posedge clk_sys);
		bus_owner <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk(pout, 2'b01);
		print_verdict;
	end

endmodule : tb
